// file: bench/acs_bench.sv
`timescale 1ns/100ps
// host and converter joined by the link, driven from the user side
module acs_bench;
  import acs_pkg::*;
  localparam int MOD_DIV = 4;
  localparam int OUT_DIV = 2;
  localparam int PER     = MOD_DIV * OUT_DIV;
  typedef struct {
    logic [1:0] mode;
    logic [1:0] gain;
    logic       bip;
    int         mode_p;
    int         rdy_p;
    logic [15:0] exp_word;
  } acs_row_t;
  // zero before full; input at zero point gives 0 or midscale, at full point all ones
  acs_row_t    rows [5] = '{'{2'h1, 2'h0, 1'b0, 6, 9, 16'h0000},
                            '{2'h1, 2'h3, 1'b1, 6, 9, 16'h8000},
                            '{2'h2, 2'h1, 1'b0, 3, 4, 16'h0000},
                            '{2'h3, 2'h2, 1'b0, 3, 4, 16'hffff},
                            '{2'h3, 2'h1, 1'b1, 3, 4, 16'hffff}};
  logic        CLK = 1'b0;
  logic        RESET = 1'b1;
  logic        start = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic [1:0]  gain = 2'h0;
  logic        bip = 1'b0;
  logic [32:0] sample = 33'h0_c000_0000;
  logic        busy, strobe, short_in, ref_in;
  logic [15:0] word;
  logic [1:0]  pga;
  int          fail_count = 0;
  int          num_checks = 0;
  int          mn, rn;
  // clock, 50 ns period
  always #25 CLK = ~CLK;
  acs_link_if acs_link_if_inst ();
  acs_dev #(.MOD_DIV(MOD_DIV), .OUT_DIV(OUT_DIV)) acs_dev_inst (.CLK(CLK), .RESET(RESET),
    .link(acs_link_if_inst), .MOD_SAMPLE(sample), .SHORT_INPUTS(short_in), .REF_INPUT(ref_in),
    .PGA_GAIN(pga));
  acs_host #(.MOD_DIV(MOD_DIV)) acs_host_inst (.CLK(CLK), .RESET(RESET), .START(start),
    .MODE(mode), .GAIN(gain), .BIPOLAR(bip), .BUSY(busy), .WORD_STROBE(strobe), .WORD(word),
    .link(acs_link_if_inst));
  acs_link_monitor #(.MOD_DIV(MOD_DIV), .OUT_DIV(OUT_DIV)) acs_link_monitor_inst (.CLK(CLK),
    .RESET(RESET), .setup_wr(acs_link_if_inst.setup_wr),
    .cal_mode_hi(acs_link_if_inst.cal_mode_hi), .cal_mode_lo(acs_link_if_inst.cal_mode_lo),
    .mode_hi_rd(acs_link_if_inst.mode_hi_rd), .mode_lo_rd(acs_link_if_inst.mode_lo_rd),
    .result_valid_n(acs_link_if_inst.result_valid_n));
  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // value compare
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // clock count compare, one clock of slack
  task automatic chk_rng(string name, int exp, int got);
    num_checks++;
    if (got < exp - 1 || got > exp + 1) begin
      fail_count++;
      $display("BAD %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic timeout(string name);
    fail_count++;
    $display("BAD %s expected event seen none", name);
    stop_test();
  endtask
  // one start pulse with the setup fields
  task automatic issue(logic [1:0] m, logic [1:0] g, logic b);
    @(posedge CLK);
    start <= 1'b1;
    mode  <= m;
    gain  <= g;
    bip   <= b;
    @(posedge CLK);
    start <= 1'b0;
  endtask
  // clocks from setup write to mode clear and ready low
  task automatic measure(logic sc, logic [1:0] g, output int mc, output int rl);
    int n;
    n  = 0;
    mc = -1;
    rl = -1;
    #1;
    while (acs_link_if_inst.setup_wr !== 1'b1) begin
      @(posedge CLK);
      #1;
      n++;
      if (n > 8) timeout("setup_wr");
    end
    n = 0;
    while (rl < 0) begin
      @(posedge CLK);
      #1;
      n++;
      if (mc < 0 && {acs_link_if_inst.mode_hi_rd, acs_link_if_inst.mode_lo_rd} === 2'h0) mc = n;
      if (acs_link_if_inst.result_valid_n === 1'b0) rl = n;
      if (n == PER) chk("short", 16'(sc), 16'(short_in));
      if (n == 4 * PER) chk("ref", 16'(sc), 16'(ref_in));
      if (n == 2) chk("gain", 16'(g), 16'(pga));
      if (n == 2) chk("busy", 16'h1, 16'(busy));
      if (n > 12 * PER) timeout("ready_n");
    end
    n = 0;
    while (strobe !== 1'b1) begin
      @(posedge CLK);
      #1;
      n++;
      if (n > 4) timeout("strobe");
    end
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge CLK);
    RESET <= 1'b0;
    #1;
    chk("ready_n", 16'h1, 16'(acs_link_if_inst.result_valid_n));
    chk("data", 16'h0, acs_link_if_inst.data);
    chk("mode", 16'h0, 16'({acs_link_if_inst.mode_hi_rd, acs_link_if_inst.mode_lo_rd}));
    repeat (2 * PER) @(posedge CLK);
    #1;
    chk("ready_n", 16'h0, 16'(acs_link_if_inst.result_valid_n));
    // input halfway between nominal zero and full points
    chk("data", 16'h8000, acs_link_if_inst.data);
    // input set before and held through each step
    foreach (rows[i]) begin
      @(posedge CLK);
      sample <= 33'(i + 1) << 28;
      issue(rows[i].mode, rows[i].gain, rows[i].bip);
      measure(rows[i].mode == 2'h1, rows[i].gain, mn, rn);
      chk_rng("mode clear", rows[i].mode_p * PER, mn);
      chk_rng("ready low", rows[i].rdy_p * PER, rn);
      chk("word", rows[i].exp_word, word);
      chk("busy", 16'h0, 16'(busy));
    end
    // abort a self step with a system zero step
    issue(2'h1, 2'h0, 1'b0);
    repeat (2 * PER) @(posedge CLK);
    issue(2'h2, 2'h1, 1'b0);
    measure(1'b0, 2'h1, mn, rn);
    chk_rng("mode clear", 3 * PER, mn);
    chk_rng("ready low", 4 * PER, rn);
    chk("word", 16'h0000, word);
    // zero code write leaves conversions running
    issue(2'h0, 2'h0, 1'b0);
    repeat (PER) @(posedge CLK);
    #1;
    chk("ready_n", 16'h0, 16'(acs_link_if_inst.result_valid_n));
    // reset in mid calibration
    issue(2'h1, 2'h0, 1'b0);
    repeat (PER) @(posedge CLK);
    RESET <= 1'b1;
    repeat (2) @(posedge CLK);
    RESET <= 1'b0;
    #1;
    chk("ready_n", 16'h1, 16'(acs_link_if_inst.result_valid_n));
    chk("mode", 16'h0, 16'({acs_link_if_inst.mode_hi_rd, acs_link_if_inst.mode_lo_rd}));
    chk("data", 16'h0, acs_link_if_inst.data);
    stop_test();
  end
endmodule // acs_bench

// file: bench/acs_link_monitor.sv
`timescale 1ns/100ps
`include "acs_cfg.svh"
// watches the link between host and converter
module acs_link_monitor #(
  parameter int MOD_DIV = `ACS_MOD_DIV,
  parameter int OUT_DIV = `ACS_OUT_DIV
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // link signals
  input wire logic setup_wr,
  input wire logic cal_mode_hi,
  input wire logic cal_mode_lo,
  input wire logic mode_hi_rd,
  input wire logic mode_lo_rd,
  input wire logic result_valid_n
);
  localparam int PER = MOD_DIV * OUT_DIV;
  logic [1:0]  code, mode_rd, cmd_ff;
  logic [15:0] cnt_ff, mode_end, rdy_end;
  logic        cmd;
  // command decode and step lengths in clocks
  assign code     = {cal_mode_hi, cal_mode_lo};
  assign mode_rd  = {mode_hi_rd, mode_lo_rd};
  assign cmd      = setup_wr && (code != `ACS_MODE_NORMAL);
  assign mode_end = 16'((cmd_ff == `ACS_MODE_SELF) ?
                        `ACS_SELF_PERIODS * PER : `ACS_STEP_PERIODS * PER);
  assign rdy_end  = 16'((cmd_ff == `ACS_MODE_SELF) ?
                        `ACS_SELF_RDY_PERIODS * PER : `ACS_SYS_RDY_PERIODS * PER);
  // clocks since the last accepted command, saturating
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cnt_ff <= 16'h0000;
      cmd_ff <= 2'h0;
    end else if (cmd) begin
      cnt_ff <= 16'h0001;
      cmd_ff <= code;
    end else if (cnt_ff != 16'h0000 && cnt_ff != 16'hffff) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  AST_CMD_READY_HIGH: assert property (cmd |=> result_valid_n)
    else $error("ready not raised after command");
  AST_MODE_ECHO: assert property (cmd |=> mode_rd == $past(code))
    else $error("mode bits do not show the command");
  AST_MODE_HOLD: assert property (cnt_ff != 16'h0000 && cnt_ff < mode_end - 16'h0001
    |-> mode_rd == cmd_ff)
    else $error("mode bits cleared early");
  AST_MODE_CLEAR: assert property (cnt_ff > mode_end + 16'h0001 |-> mode_rd == 2'h0)
    else $error("mode bits not cleared");
  AST_READY_HOLD: assert property (cnt_ff != 16'h0000 && cnt_ff < rdy_end - 16'h0001
    |-> result_valid_n)
    else $error("ready fell early");
  AST_READY_LOW: assert property (cnt_ff > rdy_end + 16'h0001 |-> !result_valid_n)
    else $error("ready did not fall");
  AST_READY_RISE_CAUSE: assert property ($rose(result_valid_n) |-> $past(cmd))
    else $error("ready rose without command");
  AST_ZERO_IGNORED: assert property (setup_wr && code == 2'h0 && mode_rd == 2'h0
    && !result_valid_n |=> !result_valid_n && mode_rd == 2'h0)
    else $error("zero code write disturbed converter");
  // main scenarios
  cover property (cmd && code == `ACS_MODE_SELF);
  cover property (cmd && code == `ACS_MODE_SYS_FULL);
  cover property ($fell(result_valid_n));
  cover property (cmd && mode_rd != 2'h0);
endmodule // acs_link_monitor

// file: hdl/acs_cfg.svh
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
// modulator cycle in master clocks
`define ACS_MOD_DIV          128
// modulator cycles per output period (filter decimation)
`define ACS_OUT_DIV          16
// output periods per step
`define ACS_STEP_PERIODS     3
// self calibration: zero step + full step
`define ACS_SELF_PERIODS     6
// coefficient setup overhead before conversion
`define ACS_SETUP_PERIODS    0
// conversion after self calibration
`define ACS_CONV_PERIODS     3
// system step: calibration + one conversion period
`define ACS_SYS_RDY_PERIODS  4
// self: total periods to ready low
`define ACS_SELF_RDY_PERIODS 9
// mode codes, hi:lo
`define ACS_MODE_NORMAL      2'h0
`define ACS_MODE_SELF        2'h1
`define ACS_MODE_SYS_ZERO    2'h2
`define ACS_MODE_SYS_FULL    2'h3
// nominal coefficients after reset
`define ACS_ZERO_NOMINAL     33'h0_8000_0000
`define ACS_FULL_NOMINAL     33'h1_0000_0000
// bipolar midscale code
`define ACS_MIDSCALE         16'h8000
`endif

// file: hdl/acs_dev.sv
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "acs_cfg.svh"
// Summary of operation
// [R1] calibration code write starts calibration anytime
// [R2] code 0,1 runs self zero then full
// [R3] self zero step shorts inputs, selected gain
// [R4] self full step converts reference over gain
// [R5] self cal six periods then clears mode
// [R6] ready high from start until new word
// [R7] self cal ready falls after nine periods
// [R8] ready rises within one modulator cycle
// [R9] host ignores ready one modulator cycle
// [R10] bipolar self zero maps to midscale
// [R11] store zero and full results, derive slope
// [R12] 33-bit internal math, 16-bit result
// [R13] system calibration: zero step then full
// [R14] code 1,0 system zero three periods
// [R15] code 1,1 system full three periods
// [R16] system cal ready falls after four periods
// [R17] host holds zero input during step
// [R18] host holds full input during step
// [R19] unipolar endpoints, bipolar midscale and full
// [R20] single system step updates own coefficient
// [R21] host recalibrates after setting changes
// [R22] reset loads nominal coefficients
// [R23] mode 0,0 converts with stored coefficients
// [R24] new command aborts and restarts sequence
module acs_dev
  import acs_pkg::*;
#(
  parameter int MOD_DIV = `ACS_MOD_DIV,
  parameter int OUT_DIV = `ACS_OUT_DIV
) (
  // clock and reset
  input  wire logic   CLK,
  input  wire logic   RESET,
  // link to host
  acs_link_if.dev     link,
  // analog front end model: modulator average of selected input
  input  wire logic [32:0] MOD_SAMPLE,
  // front end control
  output logic        SHORT_INPUTS,
  output logic        REF_INPUT,
  output logic [1:0]  PGA_GAIN
);
  acs_state_t  state_ff;
  acs_mode_t   mode_ff;
  logic [3:0]  period_cnt_ff;
  logic        rdy_n_ff;
  logic        rdy_arm_ff;
  logic [32:0] zero_coef_ff;
  logic [32:0] full_coef_ff;
  logic [15:0] data_ff;
  logic        cmd;
  logic        mod_tick;
  logic        out_tick;
  logic [1:0]  code;
  logic [3:0]  conv_periods;

  assign code = {link.cal_mode_hi, link.cal_mode_lo};
  // [R1] command detect
  assign cmd = link.setup_wr && (code != `ACS_MODE_NORMAL);

  acs_tick_div #(.MOD_DIV(MOD_DIV), .OUT_DIV(OUT_DIV)) acs_tick_div_inst (
    .CLK     (CLK),
    .RESET   (RESET),
    .restart (cmd),
    .mod_tick(mod_tick),
    .out_tick(out_tick)
  );

  // 33-bit calibrated value scaled to 16 bits
  function automatic logic [15:0] scale(input logic [32:0] raw, input logic [32:0] zc,
                                        input logic [32:0] fc, input logic bip);
    logic [32:0] span;
    logic [65:0] prod;
    logic [32:0] q;
    span = (fc > zc) ? (fc - zc) : 33'h1;
    prod = (raw > zc) ? (66'(raw - zc) << 16) : 66'h0;
    q    = 33'(prod / 66'(span));
    // [R10] bipolar zero at midscale
    if (bip) begin
      q = 33'(q >> 1) + 33'(`ACS_MIDSCALE);
    end
    scale = (q > 33'h0ffff) ? 16'hffff : q[15:0];
  endfunction

  // sequencer
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_ff      <= ACS_IDLE;
      mode_ff       <= ACS_NORMAL;
      period_cnt_ff <= 4'h0;
    // [R24] restart on new code
    end else if (cmd) begin
      mode_ff       <= acs_mode_t'(code);
      period_cnt_ff <= 4'h0;
      // [R2] self begins at zero step
      state_ff      <= (code == `ACS_MODE_SYS_FULL) ? ACS_CAL_FULL : ACS_CAL_ZERO;
    end else if (out_tick) begin
      case (state_ff)
        ACS_CAL_ZERO: begin
          // [R14] three-period step
          if (period_cnt_ff == 4'(`ACS_STEP_PERIODS - 1)) begin
            period_cnt_ff <= 4'h0;
            state_ff      <= (mode_ff == ACS_SELF) ? ACS_CAL_FULL : ACS_CONVERT;
            if (mode_ff != ACS_SELF) begin
              mode_ff <= ACS_NORMAL;
            end
          end else begin
            period_cnt_ff <= period_cnt_ff + 4'h1;
          end
        end
        ACS_CAL_FULL: begin
          // [R5] [R15] clear mode at end
          if (period_cnt_ff == 4'(`ACS_STEP_PERIODS - 1)) begin
            period_cnt_ff <= 4'h0;
            state_ff      <= ACS_CONVERT;
            mode_ff       <= ACS_NORMAL;
          end else begin
            period_cnt_ff <= period_cnt_ff + 4'h1;
          end
        end
        ACS_CONVERT: begin
          if (period_cnt_ff == conv_periods - 4'h1) begin
            period_cnt_ff <= 4'h0;
            state_ff      <= ACS_IDLE;
          end else begin
            period_cnt_ff <= period_cnt_ff + 4'h1;
          end
        end
        default: begin
          period_cnt_ff <= 4'h0;
        end
      endcase
    end
  end

  // [R7] [R16] conversion length after calibration
  assign conv_periods = (rdy_arm_ff) ?
    4'(`ACS_SELF_RDY_PERIODS - `ACS_SELF_PERIODS) :
    4'(`ACS_SYS_RDY_PERIODS - `ACS_STEP_PERIODS);

  // remembers self sequence for conversion length
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rdy_arm_ff <= 1'b0;
    end else if (cmd) begin
      rdy_arm_ff <= (code == `ACS_MODE_SELF);
    end
  end

  // [R11] [R20] [R22] coefficients, each step its own
  always_ff @(posedge CLK) begin
    if (RESET) begin
      zero_coef_ff <= `ACS_ZERO_NOMINAL;
      full_coef_ff <= `ACS_FULL_NOMINAL;
    end else if (!cmd && out_tick &&
                 period_cnt_ff == 4'(`ACS_STEP_PERIODS - 1)) begin
      // [R3] [R19] zero point stored
      if (state_ff == ACS_CAL_ZERO) begin
        zero_coef_ff <= MOD_SAMPLE;
      end
      // [R4] full point stored
      if (state_ff == ACS_CAL_FULL) begin
        full_coef_ff <= MOD_SAMPLE;
      end
    end
  end

  // [R12] [R23] conversion words from stored coefficients
  always_ff @(posedge CLK) begin
    if (RESET) begin
      data_ff <= 16'h0000;
    end else if (out_tick && !cmd && (state_ff == ACS_IDLE ||
                 (state_ff == ACS_CONVERT && period_cnt_ff == conv_periods - 4'h1))) begin
      data_ff <= scale(MOD_SAMPLE, zero_coef_ff, full_coef_ff, link.bipolar);
    end
  end

  // [R6] [R8] ready high on command, low on new word
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rdy_n_ff <= 1'b1;
    end else if (cmd) begin
      rdy_n_ff <= 1'b1;
    end else if (out_tick && (state_ff == ACS_IDLE ||
                 (state_ff == ACS_CONVERT && period_cnt_ff == conv_periods - 4'h1))) begin
      rdy_n_ff <= 1'b0;
    end
  end

  // [R3] [R4] front end steering
  always_ff @(posedge CLK) begin
    if (RESET) begin
      SHORT_INPUTS <= 1'b0;
      REF_INPUT    <= 1'b0;
      PGA_GAIN     <= 2'h0;
    end else begin
      SHORT_INPUTS <= (state_ff == ACS_CAL_ZERO) && (mode_ff == ACS_SELF);
      REF_INPUT    <= (state_ff == ACS_CAL_FULL) && rdy_arm_ff;
      PGA_GAIN     <= {link.gain_sel_hi, link.gain_sel_lo};
    end
  end

  assign link.result_valid_n = rdy_n_ff;
  assign link.data           = data_ff;
  assign link.mode_hi_rd     = mode_ff[1];
  assign link.mode_lo_rd     = mode_ff[0];
endmodule // acs_dev

// file: hdl/acs_host.sv
`timescale 1ns/100ps
`include "acs_cfg.svh"
// host end: issues commands, blanks ready after a command
module acs_host
  import acs_pkg::*;
#(
  parameter int MOD_DIV = `ACS_MOD_DIV
) (
  // clock and reset
  input  wire logic   CLK,
  input  wire logic   RESET,
  // user orders
  input  wire logic        START,
  input  wire logic [1:0]  MODE,
  input  wire logic [1:0]  GAIN,
  input  wire logic        BIPOLAR,
  // user status
  output logic        BUSY,
  output logic        WORD_STROBE,
  output logic [15:0] WORD,
  // link to converter
  acs_link_if.host    link
);
  logic [$clog2(MOD_DIV+1)-1:0] blank_ff;
  logic                         wr_ff;
  logic [1:0]                   mode_ff;
  logic [1:0]                   gain_ff;
  logic                         bip_ff;
  logic                         rdy_prev_ff;

  // setup write, one cycle; [R13] [R17] [R18] [R21] ordering is user duty
  always_ff @(posedge CLK) begin
    if (RESET) begin
      wr_ff   <= 1'b0;
      mode_ff <= `ACS_MODE_NORMAL;
      gain_ff <= 2'h0;
      bip_ff  <= 1'b0;
    end else begin
      wr_ff <= START;
      if (START) begin
        mode_ff <= MODE;
        gain_ff <= GAIN;
        bip_ff  <= BIPOLAR;
      end
    end
  end

  // [R9] ignore ready one modulator cycle
  always_ff @(posedge CLK) begin
    if (RESET) begin
      blank_ff <= '0;
    end else if (wr_ff) begin
      blank_ff <= ($clog2(MOD_DIV+1))'(MOD_DIV);
    end else if (blank_ff != '0) begin
      blank_ff <= blank_ff - 1'b1;
    end
  end

  // word capture on ready falling edge
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rdy_prev_ff <= 1'b1;
      WORD_STROBE <= 1'b0;
      WORD        <= 16'h0000;
      BUSY        <= 1'b0;
    end else begin
      rdy_prev_ff <= link.result_valid_n;
      WORD_STROBE <= 1'b0;
      BUSY        <= (blank_ff != '0) || link.mode_hi_rd || link.mode_lo_rd || wr_ff;
      if (blank_ff == '0 && !wr_ff && rdy_prev_ff && !link.result_valid_n) begin
        WORD_STROBE <= 1'b1;
        WORD        <= link.data;
      end
    end
  end

  assign link.setup_wr    = wr_ff;
  assign link.cal_mode_hi = mode_ff[1];
  assign link.cal_mode_lo = mode_ff[0];
  assign link.gain_sel_hi = gain_ff[1];
  assign link.gain_sel_lo = gain_ff[0];
  assign link.bipolar     = bip_ff;
endmodule // acs_host

// file: hdl/acs_link_if.sv
`timescale 1ns/100ps
// setup write and ready pin between host and converter
interface acs_link_if;
  logic        setup_wr;
  logic        cal_mode_hi;
  logic        cal_mode_lo;
  logic        gain_sel_hi;
  logic        gain_sel_lo;
  logic        bipolar;
  logic        mode_hi_rd;
  logic        mode_lo_rd;
  logic        result_valid_n;
  logic [15:0] data;
  modport dev  (input setup_wr, cal_mode_hi, cal_mode_lo, gain_sel_hi, gain_sel_lo, bipolar,
                output mode_hi_rd, mode_lo_rd, result_valid_n, data);
  modport host (output setup_wr, cal_mode_hi, cal_mode_lo, gain_sel_hi, gain_sel_lo, bipolar,
                input mode_hi_rd, mode_lo_rd, result_valid_n, data);
endinterface

// file: hdl/acs_pkg.sv
package acs_pkg;
  typedef enum logic [1:0] {
    ACS_NORMAL,
    ACS_SELF,
    ACS_SYS_ZERO,
    ACS_SYS_FULL
  } acs_mode_t;
  typedef enum {
    ACS_IDLE,
    ACS_CAL_ZERO,
    ACS_CAL_FULL,
    ACS_CONVERT
  } acs_state_t;
endpackage

// file: hdl/acs_tick_div.sv
`timescale 1ns/100ps
`include "acs_cfg.svh"
// master clock to modulator and output period enables
module acs_tick_div #(
  parameter int MOD_DIV = `ACS_MOD_DIV,
  parameter int OUT_DIV = `ACS_OUT_DIV
) (
  input  wire logic CLK,
  input  wire logic RESET,
  input  wire logic restart,
  output logic      mod_tick,
  output logic      out_tick
);
  logic [$clog2(MOD_DIV)-1:0] mod_cnt_ff;
  logic [$clog2(OUT_DIV)-1:0] out_cnt_ff;

  // modulator divider, realigned on restart
  always_ff @(posedge CLK) begin
    if (RESET || restart) begin
      mod_cnt_ff <= '0;
    end else if (mod_cnt_ff == ($clog2(MOD_DIV))'(MOD_DIV - 1)) begin
      mod_cnt_ff <= '0;
    end else begin
      mod_cnt_ff <= mod_cnt_ff + 1'b1;
    end
  end

  // output period divider
  always_ff @(posedge CLK) begin
    if (RESET || restart) begin
      out_cnt_ff <= '0;
    end else if (mod_tick) begin
      if (out_cnt_ff == ($clog2(OUT_DIV))'(OUT_DIV - 1)) begin
        out_cnt_ff <= '0;
      end else begin
        out_cnt_ff <= out_cnt_ff + 1'b1;
      end
    end
  end

  assign mod_tick = !restart && (mod_cnt_ff == ($clog2(MOD_DIV))'(MOD_DIV - 1));
  assign out_tick = mod_tick && (out_cnt_ff == ($clog2(OUT_DIV))'(OUT_DIV - 1));
endmodule // acs_tick_div
